// File: core/sdp_defs.svh
// Constants for the serial DAC input port.
// Assumes inclusion by bare name from core files.
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH
`define SDP_FRAME_BITS 24
`define SDP_CODE_BITS 16
`define SDP_MODE_HI 21
`define SDP_MODE_LO 20
`define SDP_CODE_HI 15
`define SDP_CODE_RESET 16'h0000
`define SDP_MODE_RESET 2'h0
`define SDP_SCLK_MAX_MHZ 30
`endif

// File: core/sdp_pkg.sv
// Types for the serial DAC input port.
// Assumes sdp_defs.svh is compiled alongside.
package sdp_pkg;
  typedef enum logic [1:0] {
    SDP_MODE_NORMAL = 2'h0,
    SDP_MODE_OPEN = 2'h1,
    SDP_MODE_100K = 2'h2,
    SDP_MODE_1K = 2'h3
  } sdp_mode_type;
  typedef enum logic [1:0] {
    SDP_IDLE = 2'h1,
    SDP_SHIFT = 2'h2
  } sdp_state_type;
endpackage

// File: core/sdp_port.sv
// Serial input port of a 16-bit DAC: shift register on the serial clock,
// converter code and mode delivered into the system clock domain.
// Assumes frame select and data meet setup to the falling serial clock edge.
`include "sdp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdp_port (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdata,
  output logic [`SDP_CODE_BITS-1:0] dac_code,
  output sdp_pkg::sdp_mode_type dac_mode,
  output logic dac_update
);
  // Link domain. The count restarts whenever frame select is high, which
  // acts as an asynchronous clear because the serial clock may stand still.
  logic [`SDP_FRAME_BITS-1:0] shreg;
  logic [4:0] bitcnt;
  logic [`SDP_FRAME_BITS-1:0] word;
  logic word_tgl;
  logic [`SDP_FRAME_BITS-1:0] next_shreg;
  logic [4:0] next_bitcnt;
  logic [`SDP_FRAME_BITS-1:0] next_word;
  logic next_word_tgl;

  always_comb begin
    next_shreg = {shreg[`SDP_FRAME_BITS-2:0], sdata};
    next_bitcnt = bitcnt + 5'h01;
    next_word = word;
    next_word_tgl = word_tgl;
    if (bitcnt == 5'(`SDP_FRAME_BITS - 1)) begin
      next_word = next_shreg;
      next_word_tgl = ~word_tgl;
      next_bitcnt = 5'h18;
    end else if (bitcnt == 5'h18) begin
      next_bitcnt = bitcnt;
      next_shreg = shreg;
    end
  end

  always_ff @(negedge sclk or posedge frame_n) begin
    if (frame_n) begin
      shreg <= '0;
      bitcnt <= 5'h00;
    end else begin
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
    end
  end

  // Word and toggle are only written on a complete frame, so an abort
  // leaves them untouched. The toggle must start known or the system side
  // never sees a change, so the system reset clears it asynchronously;
  // the serial clock stands still while reset is held.
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      word <= '0;
      word_tgl <= 1'b0;
    end else begin
      word <= next_word;
      word_tgl <= next_word_tgl;
    end
  end

  // System domain: toggle synchroniser; word is stable when toggle moves.
  logic tgl_s1, tgl_s2, tgl_s3;
  logic primed;
  logic [`SDP_CODE_BITS-1:0] next_code;
  sdp_pkg::sdp_mode_type next_mode;
  logic next_update;
  logic next_primed;

  always_comb begin
    next_code = dac_code;
    next_mode = dac_mode;
    next_update = 1'b0;
    next_primed = 1'b1;
    if (primed && (tgl_s3 != tgl_s2)) begin
      next_code = word[`SDP_CODE_HI:0];
      next_mode = sdp_pkg::sdp_mode_type'(word[`SDP_MODE_HI:`SDP_MODE_LO]);
      next_update = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      primed <= 1'b0;
      dac_code <= `SDP_CODE_RESET;
      dac_mode <= sdp_pkg::SDP_MODE_NORMAL;
      dac_update <= 1'b0;
    end else begin
      tgl_s1 <= word_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      primed <= next_primed;
      dac_code <= primed ? next_code : dac_code;
      dac_mode <= next_mode;
      dac_update <= next_update;
    end
  end

  property p_code_holds;
    @(posedge sys_clk) disable iff (!resetn)
      !dac_update |-> dac_code == $past(dac_code);
  endproperty
  a_code_holds: assert property (p_code_holds) else $error("code changed without update");

  property p_update_pulse;
    @(posedge sys_clk) disable iff (!resetn)
      dac_update |=> !dac_update;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update longer than one cycle");

  property p_abort_clear;
    @(posedge sys_clk) disable iff (!resetn)
      frame_n |-> (bitcnt == 5'h00) && (shreg == '0);
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("frame not cleared");

  property p_mode_field;
    @(posedge sys_clk) disable iff (!resetn)
      dac_update |-> dac_mode == sdp_pkg::sdp_mode_type'($past(word[`SDP_MODE_HI:`SDP_MODE_LO]));
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("mode field mismatch");

  property p_count_cap;
    @(negedge sclk) bitcnt <= 5'h18;
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("bit count past frame length");

  property p_reset_zero;
    @(posedge sys_clk) $rose(resetn) |-> (dac_code == 16'h0000) && !dac_update;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("code not zero after reset");

  c_update: cover property (@(posedge sys_clk) disable iff (!resetn) dac_update);
  c_powerdown: cover property (@(posedge sys_clk) disable iff (!resetn)
    dac_update && dac_mode != sdp_pkg::SDP_MODE_NORMAL);
  c_full: cover property (@(posedge sys_clk) disable iff (!resetn)
    dac_update && dac_code == 16'hffff);
endmodule
`default_nettype wire

// File: test/sdp_host.sv
// Host model driving frame select, serial clock and data.
// Assumes the bench calls send and leaves the lines idle otherwise.
`timescale 1ns/1ps
`default_nettype none
module sdp_host (
  output var logic sclk,
  output var logic frame_n,
  output var logic sdata
);
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    sdata = 1'b0;
  end
  // A 48 ns period keeps the clock under 30 MHz; it stands still between frames.
  task automatic send(input logic [23:0] w, input int n);
    #48 frame_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata = w[23 - (i % 24)];
      #12 sclk = 1'b1;
      #24 sclk = 1'b0;
      #12;
    end
    frame_n = 1'b1;
    sdata = ~sdata;
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Bench for the serial DAC input port with a host model on the link.
// Assumes the port, its package and header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  wire logic sclk, frame_n, sdata;
  logic [15:0] dac_code;
  sdp_pkg::sdp_mode_type dac_mode;
  logic dac_update;
  logic seen;
  int err_total = 0;
  int checks_done = 0;
  logic [41:0] rows [5] = '{{24'h000000, 18'h00000}, {24'h0fffff, 18'h0ffff},
    {24'h111234, 18'h11234}, {24'h228000, 18'h28000}, {24'hf37fff, 18'h37fff}};
  always #25 sys_clk = ~sys_clk;
  sdp_host u_sdp_host (.sclk(sclk), .frame_n(frame_n), .sdata(sdata));
  sdp_port u_sdp_port (.sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .frame_n(frame_n),
    .sdata(sdata), .dac_code(dac_code), .dac_mode(dac_mode), .dac_update(dac_update));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watching runs beside sending, so an update during the frame tail is still seen.
  task automatic frame(input logic [23:0] w, input int n);
    seen = 1'b0;
    fork
      u_sdp_host.send(w, n);
      repeat (40) @(negedge sys_clk) if (dac_update === 1'b1) seen = 1'b1;
    join
    repeat (10) @(posedge sys_clk);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    chk({dac_mode, dac_code}, 18'h00000);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      frame(rows[i][41:18], 24);
      chk({17'h0, seen}, 18'h00001);
      chk({dac_mode, dac_code}, rows[i][17:0]);
    end
    frame(24'h135555, 23);
    chk({17'h0, seen}, 18'h00000);
    chk({dac_mode, dac_code}, 18'h37fff);
    frame(24'h2abcde, 26);
    chk({dac_mode, dac_code}, 18'h2bcde);
    resetn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({dac_mode, dac_code}, 18'h00000);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    frame(24'h03abcd, 24);
    chk({17'h0, seen}, 18'h00001);
    chk({dac_mode, dac_code}, 18'h0abcd);
    close_out();
  end
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
